// File: hw/sfe_pkg.sv
// shared constants for the serial flash erase command path
package sfe_pkg;
  // ==========================================================
  // opcodes
  localparam logic [7:0] SFE_OP_BLK4K   = 8'h20;
  localparam logic [7:0] SFE_OP_BLK32K  = 8'h52;
  localparam logic [7:0] SFE_OP_BLK64K  = 8'hd8;
  localparam logic [7:0] SFE_OP_CHIP_A  = 8'h60;
  localparam logic [7:0] SFE_OP_CHIP_B  = 8'hc7;
  localparam logic [7:0] SFE_OP_WREN    = 8'h06;
  localparam logic [7:0] SFE_OP_RDSTAT  = 8'h05;
  localparam logic [7:0] SFE_OP_ASI     = 8'h25;
  // ==========================================================
  // status byte layout
  localparam int SFE_ST_BUSY = 0;
  localparam int SFE_ST_WEL  = 1;
  localparam int SFE_ST_EPE  = 5;
  localparam logic [7:0] SFE_ERASED_BYTE = 8'hff;
  localparam logic [2:0] SFE_ADDR_BYTES  = 3'h4;
  // ==========================================================
  // erase timing
  localparam int SFE_CLK_MHZ          = 200;
  localparam int SFE_BLOCK_ERASE_TIME_US = 50;
  localparam int SFE_ARRAY_ERASE_TIME_US = 400;
  localparam int SFE_BLOCK_ERASE_CYC  =
    SFE_BLOCK_ERASE_TIME_US * SFE_CLK_MHZ;
  localparam int SFE_ARRAY_ERASE_CYC  =
    SFE_ARRAY_ERASE_TIME_US * SFE_CLK_MHZ;
  localparam int SFE_SCK_HALF         = 8;
  // ==========================================================
  // host registers
  localparam logic [3:0] SFE_REG_CTRL = 4'h0;
  localparam logic [3:0] SFE_REG_ADDR = 4'h4;
  localparam logic [3:0] SFE_REG_STAT = 4'h8;
  localparam int SFE_CTL_AB    = 8;
  localparam int SFE_CTL_RD    = 11;
  localparam int SFE_CTL_XB    = 12;
  localparam int SFE_CTL_ASI   = 15;
  localparam int SFE_STA_BUSY  = 0;
  localparam int SFE_STA_ASI   = 1;
  localparam int SFE_STA_RX    = 8;
  // ==========================================================
  typedef enum logic [1:0] {
    SFE_SZ_4K   = 2'b00,
    SFE_SZ_32K  = 2'b01,
    SFE_SZ_64K  = 2'b10,
    SFE_SZ_CHIP = 2'b11
  } sfe_size_t;
endpackage

// File: hw/sfe_link_if.sv
// serial link between flash controller and erase command logic
`timescale 1ns/10ps
interface sfe_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so_o;
  logic so_oe;
  wire  so;
  // pulled high when the flash does not drive
  assign so = so_oe ? so_o : 1'b1;
  modport flash (input sck, input cs_n, input si, output so_o,
                 output so_oe);
  modport ctrl (output sck, output cs_n, output si, input so);
endinterface

// File: hw/sfe_device.sv
// flash side: erase command decode, checks and self-timed erase
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module sfe_device
  import sfe_pkg::*;
#(
  parameter int BLK_IDX_W      = 7,
  parameter int BLOCK_ERASE_CYC = sfe_pkg::SFE_BLOCK_ERASE_CYC,
  parameter int ARRAY_ERASE_CYC = sfe_pkg::SFE_ARRAY_ERASE_CYC
)(
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  sfe_link_if.flash                    link,
  input  wire logic [2**BLK_IDX_W-1:0] prot_blocks,
  input  wire logic                    erase_fail,
  output logic                         erase_req,
  output logic [31:0]                  erase_base,
  output sfe_pkg::sfe_size_t           erase_size,
  output logic [7:0]                   erase_fill,
  output logic                         busy,
  output logic                         write_enable_latch
);
  import sfe_pkg::*;

  // ==========================================================
  // link synchronisers
  logic sck_q1, sck_q2, sck_q3;
  logic cs_q1, cs_q2, cs_q3;
  logic si_q1, si_q2;

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      {sck_q1, sck_q2, sck_q3} <= 3'h0;
      {cs_q1, cs_q2, cs_q3}    <= 3'h7;
      {si_q1, si_q2}           <= 2'h0;
    end
    else
    begin
      {sck_q1, sck_q2, sck_q3} <= {link.sck, sck_q1, sck_q2};
      {cs_q1, cs_q2, cs_q3}    <= {link.cs_n, cs_q1, cs_q2};
      {si_q1, si_q2}           <= {link.si, si_q1};
    end

  wire sck_rise = sck_q2 & ~sck_q3;
  wire sck_fall = ~sck_q2 & sck_q3;
  wire in_frame = ~cs_q2;
  wire cs_rise  = cs_q2 & ~cs_q3;

  // ==========================================================
  // byte assembly
  logic [2:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic [6:0]  shreg;
  logic [7:0]  opcode;
  logic [31:0] addr;

  wire       take     = in_frame & sck_rise;
  wire       byte_end = take & (bit_cnt == 3'h7);
  wire [7:0] byte_val = {shreg, si_q2};

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shreg    <= 7'h00;
      opcode   <= 8'h00;
      addr     <= 32'h0;
    end
    else if (!in_frame)
    begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      opcode   <= 8'h00;
    end
    else if (take)
    begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg   <= byte_val[6:0];
      if (byte_end && byte_cnt == 3'h0)
        opcode <= byte_val;
      if (byte_end && byte_cnt != 3'h0 && byte_cnt <= SFE_ADDR_BYTES)
        addr <= {addr[23:0], byte_val};
      if (byte_end && byte_cnt != 3'h7)
        byte_cnt <= byte_cnt + 3'h1;
    end

  // ==========================================================
  // decisions at chip select release
  function automatic logic [31:0] sfe_low_mask(input sfe_size_t sz);
    case (sz)
      SFE_SZ_4K:  sfe_low_mask = 32'h0000_0fff;
      SFE_SZ_32K: sfe_low_mask = 32'h0000_7fff;
      SFE_SZ_64K: sfe_low_mask = 32'h0000_ffff;
      default:    sfe_low_mask = 32'hffff_ffff;
    endcase
  endfunction

  wire is_blk  = (opcode == SFE_OP_BLK4K) | (opcode == SFE_OP_BLK32K)
               | (opcode == SFE_OP_BLK64K);
  wire is_chip = (opcode == SFE_OP_CHIP_A)
               | (opcode == SFE_OP_CHIP_B);
  wire is_wren = opcode == SFE_OP_WREN;
  // partial final byte voids the whole frame
  wire whole   = (bit_cnt == 3'h0) & (byte_cnt != 3'h0);
  wire len_ok  = byte_cnt > SFE_ADDR_BYTES;
  // 4K and 32K blocks sit inside one 64K block
  wire blk_prot  = prot_blocks[addr[16 +: BLK_IDX_W]];
  wire chip_prot = |prot_blocks;
  wire erase_op  = (is_blk | is_chip) & write_enable_latch;
  wire erase_ok  = whole & (is_chip ? ~chip_prot
                                    : len_ok & ~blk_prot);
  // the running erase owns the array; new erase opcodes are dropped
  wire act       = cs_rise & ~busy;

  wire sfe_size_t next_size =
    (opcode == SFE_OP_BLK4K)  ? SFE_SZ_4K  :
    (opcode == SFE_OP_BLK32K) ? SFE_SZ_32K :
    (opcode == SFE_OP_BLK64K) ? SFE_SZ_64K : SFE_SZ_CHIP;

  // ==========================================================
  // self-timed erase
  logic [31:0] cnt;
  logic        erase_program_error_flag;

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      busy       <= 1'b0;
      write_enable_latch        <= 1'b0;
      erase_program_error_flag        <= 1'b0;
      cnt        <= 32'h0;
      erase_req  <= 1'b0;
      erase_base <= 32'h0;
      erase_size <= SFE_SZ_4K;
      erase_fill <= 8'h00;
    end
    else
    begin
      erase_req <= 1'b0;
      if (act && is_wren && whole)
        write_enable_latch <= 1'b1;
      if (act && erase_op && erase_ok)
      begin
        busy       <= 1'b1;
        write_enable_latch        <= 1'b0;
        erase_program_error_flag        <= 1'b0;
        erase_req  <= 1'b1;
        erase_size <= next_size;
        erase_base <= addr & ~sfe_low_mask(next_size);
        erase_fill <= SFE_ERASED_BYTE;
        cnt <= is_chip ? 32'(ARRAY_ERASE_CYC)
                       : 32'(BLOCK_ERASE_CYC);
      end
      else if (act && erase_op)
        write_enable_latch <= 1'b0;
      if (busy)
      begin
        cnt <= cnt - 32'h1;
        if (cnt == 32'h1)
        begin
          busy <= 1'b0;
          erase_program_error_flag  <= erase_fail;
        end
      end
    end

  // ==========================================================
  // status output and active status signal
  logic [7:0] status;
  logic [7:0] tx_sh;
  logic       rd_mode;
  logic       asi;

  always_comb
  begin
    status = 8'h00;
    status[SFE_ST_BUSY] = busy;
    status[SFE_ST_WEL]  = write_enable_latch;
    status[SFE_ST_EPE]  = erase_program_error_flag;
  end

  wire op_rd  = byte_end & (byte_cnt == 3'h0)
              & ((byte_val == SFE_OP_RDSTAT) | (byte_val == SFE_OP_ASI));
  wire asi_on = byte_end & (byte_cnt == 3'h1)
              & (opcode == SFE_OP_ASI);

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      tx_sh       <= 8'h00;
      rd_mode     <= 1'b0;
      asi         <= 1'b0;
      link.so_o   <= 1'b0;
      link.so_oe  <= 1'b0;
    end
    else if (!in_frame)
    begin
      rd_mode    <= 1'b0;
      asi        <= 1'b0;
      link.so_oe <= 1'b0;
    end
    else
    begin
      if (op_rd)
        rd_mode <= 1'b1;
      if (op_rd || (rd_mode && byte_end))
        tx_sh <= status;
      if (asi_on)
        asi <= 1'b1;
      link.so_oe <= rd_mode;
      // sck may stop after 16 clocks, so follow busy directly
      if (asi)
        link.so_o <= busy;
      else if (rd_mode && sck_fall)
      begin
        link.so_o <= tx_sh[7];
        tx_sh     <= {tx_sh[6:0], 1'b0};
      end
    end

endmodule

// File: hw/sfe_host.sv
// controller side: ahb-lite registers driving flash frames
`timescale 1ns/10ps
module sfe_host
  import sfe_pkg::*;
#(
  parameter int SCK_HALF = sfe_pkg::SFE_SCK_HALF
)(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  sfe_link_if.ctrl         link,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  import sfe_pkg::*;

  typedef enum logic [2:0] {
    SFE_H_IDLE = 3'b000,
    SFE_H_LEAD = 3'b001,
    SFE_H_LOW  = 3'b010,
    SFE_H_HIGH = 3'b011,
    SFE_H_ASI  = 3'b100,
    SFE_H_TAIL = 3'b101
  } sfe_hstate_t;

  // ==========================================================
  // bus slave, zero wait states
  logic        wr_pend;
  logic [3:0]  wr_addr;
  logic [31:0] addr_reg;
  logic [15:0] ctrl_reg;
  logic [7:0]  rx_byte;
  logic        asi_done;
  sfe_hstate_t st;

  wire        ap     = hsel & htrans[1] & hready;
  wire [3:0]  a_lo   = haddr[3:0];
  wire        f_busy = st != SFE_H_IDLE;
  wire        go     = wr_pend & (wr_addr == SFE_REG_CTRL) & ~f_busy;
  wire [31:0] stat   = {16'h0, rx_byte, 6'h0, asi_done, f_busy};
  wire [31:0] rdata  = (a_lo == SFE_REG_CTRL) ? {16'h0, ctrl_reg} :
                       (a_lo == SFE_REG_ADDR) ? addr_reg :
                       (a_lo == SFE_REG_STAT) ? stat : 32'h0;

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      wr_pend   <= 1'b0;
      wr_addr   <= 4'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      addr_reg  <= 32'h0;
      ctrl_reg  <= 16'h0;
    end
    else
    begin
      wr_pend <= ap & hwrite;
      wr_addr <= a_lo;
      if (ap && !hwrite)
        hrdata <= rdata;
      if (wr_pend && wr_addr == SFE_REG_ADDR)
        addr_reg <= hwdata;
      // a frame in flight keeps its command
      if (go)
        ctrl_reg <= hwdata[15:0];
    end

  // ==========================================================
  // frame engine
  logic       so_q1, so_q2;
  logic [7:0] div;
  logic [6:0] bits;
  logic [47:0] tx;
  logic [7:0] rx;

  wire       half  = div == 8'(SCK_HALF - 1);
  wire [2:0] nab   = hwdata[SFE_CTL_AB +: 3];
  wire [6:0] nbits = 7'd8 + {1'b0, nab, 3'h0}
                   + (hwdata[SFE_CTL_RD] ? 7'd8 : 7'd0)
                   + {4'h0, hwdata[SFE_CTL_XB +: 3]};

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      {so_q1, so_q2} <= 2'h3;
    else
      {so_q1, so_q2} <= {link.so, so_q1};

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      st        <= SFE_H_IDLE;
      div       <= 8'h0;
      bits      <= 7'h0;
      tx        <= 48'h0;
      rx        <= 8'h0;
      rx_byte   <= 8'h0;
      asi_done  <= 1'b0;
      link.sck  <= 1'b0;
      link.cs_n <= 1'b1;
      link.si   <= 1'b0;
    end
    else
    begin
      div <= (half || st == SFE_H_IDLE) ? 8'h0 : div + 8'h1;
      case (st)
        SFE_H_IDLE:
          if (go)
          begin
            tx        <= {hwdata[7:0], addr_reg, 8'h00};
            bits      <= nbits;
            asi_done  <= 1'b0;
            link.cs_n <= 1'b0;
            st        <= SFE_H_LEAD;
          end
        SFE_H_LEAD:
          if (half)
          begin
            link.si <= tx[47];
            st      <= SFE_H_LOW;
          end
        SFE_H_LOW:
          if (half)
          begin
            link.sck <= 1'b1;
            rx       <= {rx[6:0], so_q2};
            st       <= SFE_H_HIGH;
          end
        SFE_H_HIGH:
          if (half)
          begin
            link.sck <= 1'b0;
            link.si  <= tx[46];
            tx       <= {tx[46:0], 1'b0};
            bits     <= bits - 7'h1;
            if (bits != 7'h1)
              st <= SFE_H_LOW;
            else if (ctrl_reg[SFE_CTL_ASI])
              st <= SFE_H_ASI;
            else
            begin
              rx_byte   <= rx;
              link.cs_n <= 1'b1;
              st        <= SFE_H_TAIL;
            end
          end
        SFE_H_ASI:
          if (!so_q2)
          begin
            asi_done  <= 1'b1;
            rx_byte   <= rx;
            link.cs_n <= 1'b1;
            st        <= SFE_H_TAIL;
          end
        SFE_H_TAIL:
          if (half)
            st <= SFE_H_IDLE;
        default:
          st <= SFE_H_IDLE;
      endcase
    end

endmodule

// File: tb/sfe_erase_props.sv
// assertions on the erase link and the device status outputs
`timescale 1ns/10ps
module sfe_erase_props #(
  parameter int BLK = 1500,
  parameter int ARR = 2500
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic so,
  input wire logic erase_req,
  input wire logic busy,
  input wire logic write_enable_latch
);
  // ==========================================================
  // busy length counter
  logic [15:0] bcnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      bcnt <= 16'h0;
    else
      bcnt <= busy ? bcnt + 16'h1 : 16'h0;
  end
  // ==========================================================
  // properties
  a_busy_hold: assert property (erase_req |=> busy[*8])
    else $error("busy not held after erase start");
  a_start_released: assert property (erase_req |-> cs_n)
    else $error("erase started inside a frame");
  a_wel_cleared: assert property (erase_req |-> ##[0:1] !write_enable_latch)
    else $error("latch still set after erase start");
  a_no_start_busy: assert property (busy && $past(busy) |-> !erase_req)
    else $error("erase accepted while busy");
  a_wel_stays_low: assert property (busy && $past(busy) |-> !$rose(write_enable_latch))
    else $error("latch set while busy");
  // timed length traded for a one-cycle tolerance on sync latency
  a_busy_length: assert property ($fell(busy) |->
    (bcnt >= BLK - 1 && bcnt <= BLK + 1) ||
    (bcnt >= ARR - 1 && bcnt <= ARR + 1))
    else $error("busy length wrong");
  a_so_release: assert property ($rose(cs_n) |-> ##[0:8] !so_oe)
    else $error("output still driven after frame");
  a_sck_idle: assert property (cs_n |-> !sck)
    else $error("link clock runs outside frame");
  a_cs_gap: assert property ($rose(cs_n) |=> cs_n[*7])
    else $error("select gap too short");
endmodule

// File: tb/serial_flash_erase_commands_bench.sv
// self-checking bench: host and device joined over the link
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module serial_flash_erase_commands_bench;
  import sfe_pkg::*;
  localparam int BLK = 1500;
  localparam int ARR = 2500;
  logic         ref_clk = 0, resetn = 0, hsel = 0, hwrite = 0;
  logic         erase_fail = 0, hreadyout, hresp, erase_req, busy, write_enable_latch;
  logic [1:0]   htrans = 0;
  logic [31:0]  haddr = 0, hwdata = 0, hrdata, erase_base, got_base, r, a;
  logic [127:0] prot_blocks = 0;
  logic [7:0]   erase_fill, st, op;
  sfe_size_t    erase_size, got_size;
  logic [7:0]   ops [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
  int           n_mismatch = 0, checks = 0, n_req = 0, nr, i;
  int           seed = 32'hd24b;
  sfe_link_if link ();
  sfe_host sfe_host_inst (.ref_clk, .resetn, .link(link), .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp);
  sfe_device #(.BLOCK_ERASE_CYC(BLK), .ARRAY_ERASE_CYC(ARR)) sfe_device_inst
    (.ref_clk, .resetn, .link(link), .prot_blocks, .erase_fail, .erase_req,
    .erase_base, .erase_size, .erase_fill, .busy, .write_enable_latch);
  sfe_erase_props #(.BLK(BLK), .ARR(ARR)) sfe_erase_props_inst (.ref_clk,
    .resetn, .sck(link.sck), .cs_n(link.cs_n), .si(link.si),
    .so_o(link.so_o), .so_oe(link.so_oe), .so(link.so), .erase_req, .busy,
    .write_enable_latch);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (erase_req === 1'b1)
    begin
      n_req++;
      got_base = erase_base;
      got_size = erase_size;
    end
  end
  // ==========================================================
  // expectations
  function automatic logic [31:0] ctl(logic [7:0] o, logic [2:0] ab,
    logic rd, logic [2:0] xb, logic asi);
    return {16'h0, asi, xb, rd, ab, o};
  endfunction
  function automatic sfe_size_t exp_size(logic [7:0] o);
    return sfe_size_t'(o == 8'h20 ? 0 : o == 8'h52 ? 1 : o == 8'hd8 ? 2 : 3);
  endfunction
  function automatic logic [31:0] exp_base(logic [7:0] o, logic [31:0] d);
    return o == 8'h20 ? d & ~32'hfff : o == 8'h52 ? d & ~32'h7fff
      : d & ~32'hffff;
  endfunction
  // ==========================================================
  // bus and frame tasks
  task automatic ahb(input logic w, input logic [31:0] ad, d,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= ad;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // polls frame busy; the watchdog covers a stuck host
  task automatic frame(input logic [31:0] c, ad);
    logic [31:0] t;
    ahb(1'b1, 32'h4, ad, t);
    ahb(1'b1, 32'h0, c, t);
    t = 32'h1;
    while (t[0] !== 1'b0)
      ahb(1'b0, 32'h8, 32'h0, t);
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic status();
    frame(ctl(SFE_OP_RDSTAT, 3'h0, 1'b1, 3'h0, 1'b0), 32'h0);
    ahb(1'b0, 32'h8, 32'h0, r);
    st = r[15:8];
  endtask
  task automatic wren();
    frame(ctl(SFE_OP_WREN, 3'h0, 1'b0, 3'h0, 1'b0), 32'h0);
  endtask
  task automatic denied(input logic [31:0] c, ad);
    wren();
    nr = n_req;
    frame(c, ad);
    `CHK(n_req, nr)
    `CHK(write_enable_latch, 1'b0)
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ahb(1'b0, 32'hc, 32'h0, r);
    `CHK(r, 32'h0)
    a = $random(seed) & 32'h007f_ffff;
    frame(ctl(8'h20, 3'h4, 1'b0, 3'h0, 1'b0), a);
    `CHK(n_req, 0)
    for (int k = 0; k < 5; k++)
    begin
      op = ops[k];
      a = $random(seed) & 32'h007f_ffff;
      erase_fail <= 1'($random(seed));
      nr = n_req;
      wren();
      `CHK(write_enable_latch, 1'b1)
      frame(ctl(op, k < 3 ? 3'h4 : 3'h0, 1'b1, 3'h0, 1'b0), a);
      `CHK(n_req, nr + 1)
      `CHK(got_size, exp_size(op))
      if (k < 3) `CHK(got_base, exp_base(op, a))
      status();
      `CHK(st[1:0], 2'b01)
      if (k == 0) frame(ctl(8'h52, 3'h4, 1'b0, 3'h0, 1'b0), a);
      if (k == 0) `CHK(n_req, nr + 1)
      if (k == 1)
      begin
        // the active status wait needs the full 16 clocks first
        frame(ctl(SFE_OP_ASI, 3'h0, 1'b1, 3'h0, 1'b1), 32'h0);
        `CHK(busy, 1'b0)
        ahb(1'b0, 32'h8, 32'h0, r);
        `CHK(r[1], 1'b1)
      end
      i = 0;
      while (busy !== 1'b0 && i < 5000)
      begin
        @(posedge ref_clk);
        i++;
      end
      `CHK(erase_fill, SFE_ERASED_BYTE)
      status();
      `CHK(st[5], erase_fail)
    end
    denied(ctl(8'hd8, 3'h3, 1'b0, 3'h0, 1'b0), a);
    denied(ctl(8'h52, 3'h4, 1'b0, 3'h3, 1'b0), a);
    denied(ctl(8'h60, 3'h0, 1'b0, 3'h5, 1'b0), 32'h0);
    prot_blocks <= 128'h1 << a[22:16];
    denied(ctl(8'h20, 3'h4, 1'b0, 3'h0, 1'b0), a);
    denied(ctl(8'hc7, 3'h0, 1'b0, 3'h0, 1'b0), 32'h0);
    stop_test();
  end
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
